// *** design/ccdec_pkg.sv ***
package ccdec_pkg;

    // ***********************************************
    // clock and bit timing
    // ***********************************************
    localparam int CLK_KHZ       = 10000;
    localparam int BIT_PS        = 1986500;   // one caption bit, 503.4 kHz
    localparam int BIT_CYC       = (BIT_PS * (CLK_KHZ / 1000)) / 1000000;
    localparam int HALF_CYC      = BIT_CYC / 2;
    localparam int DIV_W         = 5;
    localparam int RUNIN_EDGES   = 4;
    localparam int START_MAX     = 8;
    localparam int BYTE_BITS     = 8;

    // ***********************************************
    // line selection
    // ***********************************************
    localparam logic [8:0] LINE_ODD_BASE  = 9'h001;
    localparam logic [8:0] LINE_EVEN_BASE = 9'h108;   // first line of the even field
    localparam logic [8:0] LINE_CAPTION   = 9'h015;   // line 21
    localparam logic [8:0] LINE_EXTENDED  = 9'h11C;   // line 284
    localparam logic [2:0] START_CODE     = 3'h1;     // 0, 0, 1 in arrival order

    // ***********************************************
    // fifo
    // ***********************************************
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_HALF  = 8;
    localparam int PTR_W      = 4;
    localparam int CNT_W      = 5;

    typedef struct packed {
        logic       svc;    // service_type_tag: 1 = extended service
        logic       half;   // byte_half_tag: 1 = high byte
        logic [7:0] data;   // 7-bit character, parity in bit 7
    } ccdec_entry_t;

    // ***********************************************
    // register map (index, byte address = index * 4)
    // ***********************************************
    localparam logic [7:0] IDX_DEVICE_STATUS = 8'h00;
    localparam logic [7:0] IDX_FIFO_STATUS   = 8'h1F;
    localparam logic [7:0] IDX_FIFO_READ     = 8'h20;
    localparam logic [7:0] IDX_IRQ_STATUS    = 8'h30;
    localparam logic [7:0] IDX_IRQ_MASK      = 8'h31;
    localparam int         ADDR_W            = 10;

    // caption_fifo_status fields
    localparam int FS_NONEMPTY = 0;
    localparam int FS_OVERFLOW = 1;
    localparam int FS_HALF_TAG = 2;
    localparam int FS_SVC_TAG  = 3;
    localparam int FS_PARITY   = 4;
    localparam int FS_INT_EN   = 5;
    localparam int FS_CC_EN    = 6;
    localparam int FS_EDS_EN   = 7;
    localparam int DS_HALF_IRQ = 0;

    // interrupt status / mask fields
    localparam int EV_HALF   = 0;
    localparam int EV_OVF    = 1;
    localparam int EV_PARITY = 2;
    localparam int EV_W      = 3;

    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam logic [7:0] SLICE_LVL  = 8'h60;

    typedef enum {S_IDLE, S_RUNIN, S_START, S_LO, S_HI} ccdec_state_t;

endpackage : ccdec_pkg

// *** design/ccdec_top.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - caption line 21 odd, extended 284 even
// - slice luma only, after separation
// - separate enables for caption and extended
// - target line, run-in, then start 001
// - seven-bit character plus odd parity bit
// - sixteen by ten bit fifo
// - low byte first if not full, then high
// - tags for service and byte half
// - parity bit stored, check result reported
// - nonempty flag low only when empty
// - half full drives enabled interrupt pin
// - half-full status bit polled at 0x00
// - head shown at once, read advances
// - byte into full fifo dropped, overflow set
// - data read clears overflow
// - read wins over coincident write
// - coincident write keeps overflow set
// - both disabled flushes the fifo
module ccdec_top
    import ccdec_pkg::*;
(
    // clock and reset
    input  wire logic              I_CLK,
    input  wire logic              I_SYS_RST,
    // separated luma path
    input  wire logic [7:0]        I_LUMA,
    input  wire logic              I_LINE_START,
    input  wire logic              I_FIELD_START,
    input  wire logic              I_FIELD_ODD,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
    input  wire logic              I_AVS_READ,
    input  wire logic              I_AVS_WRITE,
    input  wire logic [31:0]       I_AVS_WRITEDATA,
    input  wire logic [3:0]        I_AVS_BYTEENABLE,
    output logic      [31:0]       O_AVS_READDATA,
    output logic                   O_AVS_WAITREQUEST,
    // interrupts
    output logic                   O_CC_IRQ,
    output logic                   O_IRQ
);

    // ***********************************************
    // declarations
    // ***********************************************
    ccdec_state_t     state_q;
    logic [8:0]       line_q;
    logic             sliced;
    logic             sliced_q;
    logic [DIV_W-1:0] div_q;
    logic             bit_en;
    logic [3:0]       cnt_q;
    logic [2:0]       start_q;
    logic [7:0]       byte_q;
    logic [7:0]       byte_d;
    logic             target;
    logic             svc_q;
    logic             push_req;
    ccdec_entry_t     push_entry;
    ccdec_entry_t     mem [FIFO_DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [CNT_W-1:0] count_q;
    logic             full;
    logic             half;
    logic             half_q;
    logic             push_ok;
    logic             pop;
    logic             flush;
    logic             ovf_q;
    ccdec_entry_t     head;
    logic             par_fault;
    logic             int_en_q;
    logic             cc_en_q;
    logic             eds_en_q;
    logic [EV_W-1:0]  ev;
    logic [EV_W-1:0]  irq_stat_q;
    logic [EV_W-1:0]  irq_mask_q;
    logic             req;
    logic             acc;
    logic             pop_ok_q;
    logic [7:0]       idx;
    logic [7:0]       rd_val;
    logic [7:0]       fifo_status;

    // ***********************************************
    // line counting and slicing
    // ***********************************************
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            line_q <= 9'h000;
        end else if (I_FIELD_START) begin
            line_q <= I_FIELD_ODD ? LINE_ODD_BASE : LINE_EVEN_BASE;
        end else if (I_LINE_START) begin
            line_q <= line_q + 9'h001;
        end
    end

    // line start arrives together with the counter step, so compare the next line
    assign target = I_FIELD_ODD ? (cc_en_q && (line_q + 9'h001) == LINE_CAPTION)
                                : (eds_en_q && (line_q + 9'h001) == LINE_EXTENDED);
    assign sliced = I_LUMA > SLICE_LVL;

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            sliced_q <= 1'b0;
        end else begin
            sliced_q <= sliced;
        end
    end

    // bit phase locks to each run-in rising edge; sample lands mid-bit
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            div_q <= '0;
        end else if (state_q == S_RUNIN && sliced && !sliced_q) begin
            div_q <= DIV_W'(HALF_CYC);
        end else if (div_q == DIV_W'(BIT_CYC - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign bit_en = div_q == DIV_W'(BIT_CYC - 1);

    // ***********************************************
    // capture sequencer
    // ***********************************************
    assign byte_d = {sliced, byte_q[7:1]};    // lsb first

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            state_q <= S_IDLE;
            cnt_q   <= '0;
            start_q <= '0;
            byte_q  <= '0;
            svc_q   <= 1'b0;
        end else if (I_LINE_START) begin
            state_q <= target ? S_RUNIN : S_IDLE;
            cnt_q   <= '0;
            start_q <= '1;
            svc_q   <= !I_FIELD_ODD;
        end else begin
            case (state_q)
                S_RUNIN: begin
                    if (sliced && !sliced_q) begin
                        cnt_q <= cnt_q + 1'b1;
                        if (cnt_q == 4'(RUNIN_EDGES - 1)) begin
                            state_q <= S_START;
                            cnt_q   <= '0;
                        end
                    end
                end
                S_START: begin
                    if (bit_en) begin
                        start_q <= {start_q[1:0], sliced};
                        cnt_q   <= cnt_q + 1'b1;
                        if ({start_q[1:0], sliced} == START_CODE) begin
                            state_q <= S_LO;
                            cnt_q   <= '0;
                        end else if (cnt_q == 4'(START_MAX - 1)) begin
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_LO, S_HI: begin
                    if (bit_en) begin
                        byte_q <= byte_d;
                        cnt_q  <= cnt_q + 1'b1;
                        if (cnt_q == 4'(BYTE_BITS - 1)) begin
                            cnt_q   <= '0;
                            state_q <= (state_q == S_LO) ? S_HI : S_IDLE;
                        end
                    end
                end
                S_IDLE: begin
                    cnt_q <= '0;
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // full byte: 7-bit character with parity in bit 7
    assign push_req = !I_LINE_START && bit_en && (state_q == S_LO || state_q == S_HI)
                      && cnt_q == 4'(BYTE_BITS - 1);
    assign push_entry = '{svc: svc_q, half: state_q == S_HI, data: byte_d};

    // ***********************************************
    // fifo
    // ***********************************************
    assign full    = count_q == CNT_W'(FIFO_DEPTH);
    assign half    = count_q >= CNT_W'(FIFO_HALF);
    // held while both enables are off, so nothing lands between two writes
    assign flush   = !cc_en_q && !eds_en_q;
    // room is judged before the read of this cycle: a slot the read frees is not reused by the write
    assign push_ok = push_req && !full && !flush;
    assign head    = mem[rd_ptr_q];
    assign par_fault = !(^head.data);

    always_ff @(posedge I_CLK) begin
        if (push_ok) begin
            mem[wr_ptr_q] <= push_entry;
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else if (flush) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            if (push_ok) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            count_q <= count_q + CNT_W'(push_ok) - CNT_W'(pop);
        end
    end

    // set wins over clear; a read alongside a write attempt never clears
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            ovf_q <= 1'b0;
        end else if (flush) begin
            ovf_q <= 1'b0;
        end else if (push_req && full) begin
            ovf_q <= 1'b1;
        end else if (pop && !push_req) begin
            ovf_q <= 1'b0;
        end
    end

    // ***********************************************
    // interrupts
    // ***********************************************
    assign ev = {push_ok && !(^push_entry.data), push_req && full, half && !half_q};

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            half_q     <= 1'b0;
            irq_stat_q <= '0;
        end else begin
            half_q <= half;
            if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0] && idx == IDX_IRQ_STATUS) begin
                irq_stat_q <= (irq_stat_q & ~I_AVS_WRITEDATA[EV_W-1:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    // pin follows the level, so it drops by itself once software drains below half
    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_CC_IRQ <= 1'b0;
            O_IRQ    <= 1'b0;
        end else begin
            O_CC_IRQ <= half && int_en_q;
            O_IRQ    <= |(irq_stat_q & irq_mask_q);
        end
    end

    // ***********************************************
    // avalon-mm slave: fixed one wait state
    // ***********************************************
    assign req = I_AVS_READ || I_AVS_WRITE;
    assign acc = req && !O_AVS_WAITREQUEST;
    assign idx = I_AVS_ADDRESS[ADDR_W-1:2];
    // head is only popped if it was really there when the data was latched
    assign pop = acc && I_AVS_READ && idx == IDX_FIFO_READ && pop_ok_q && count_q != '0;

    assign fifo_status = {eds_en_q, cc_en_q, int_en_q, par_fault && count_q != '0,
                          head.svc && count_q != '0, head.half && count_q != '0,
                          ovf_q, count_q != '0};

    always_comb begin
        rd_val = 8'h00;
        case (idx)
            IDX_DEVICE_STATUS: rd_val[DS_HALF_IRQ] = half;
            IDX_FIFO_STATUS:   rd_val = fifo_status;
            IDX_FIFO_READ:     rd_val = (count_q != '0) ? head.data : 8'h00;
            IDX_IRQ_STATUS:    rd_val[EV_W-1:0] = irq_stat_q;
            IDX_IRQ_MASK:      rd_val[EV_W-1:0] = irq_mask_q;
            default:           rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_AVS_WAITREQUEST <= 1'b1;
            O_AVS_READDATA    <= 32'h0000_0000;
            pop_ok_q          <= 1'b0;
        end else begin
            O_AVS_WAITREQUEST <= !(req && O_AVS_WAITREQUEST);
            if (req && O_AVS_WAITREQUEST) begin
                O_AVS_READDATA <= {24'h00_0000, rd_val};
                pop_ok_q       <= count_q != '0;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            {eds_en_q, cc_en_q, int_en_q} <= CTRL_RESET;
            irq_mask_q                    <= '0;
        end else if (acc && I_AVS_WRITE && I_AVS_BYTEENABLE[0]) begin
            if (idx == IDX_FIFO_STATUS) begin
                {eds_en_q, cc_en_q, int_en_q} <= I_AVS_WRITEDATA[FS_EDS_EN:FS_INT_EN];
            end
            if (idx == IDX_IRQ_MASK) begin
                irq_mask_q <= I_AVS_WRITEDATA[EV_W-1:0];
            end
        end
    end

    // ***********************************************
    // assertions
    // ***********************************************
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SYS_RST);

    a_full_drop: assert property (push_req && full && !pop && !flush
                                  |=> count_q == CNT_W'(FIFO_DEPTH))
        else $error("byte stored into full fifo");
    a_ovf_set: assert property (push_req && full && !flush |=> ovf_q)
        else $error("overflow not set on drop");
    a_ovf_clear: assert property (ovf_q && pop && !push_req && !flush |=> !ovf_q)
        else $error("overflow not cleared by read");
    a_ovf_keep: assert property (ovf_q && pop && push_req && !flush |=> ovf_q)
        else $error("overflow cleared during write");
    a_read_first: assert property (pop && push_req && full && !flush
                                   |=> count_q == CNT_W'(FIFO_DEPTH - 1))
        else $error("write took freed slot");
    a_flush_empty: assert property (flush |=> count_q == '0 && !ovf_q)
        else $error("fifo not flushed");
    a_irq_raise: assert property ((half && int_en_q) [*2] |-> O_CC_IRQ)
        else $error("caption pin not asserted");
    a_irq_drop: assert property ((!half || !int_en_q) [*2] |-> !O_CC_IRQ)
        else $error("caption pin stuck high");
    a_byte_order: assert property (push_req && push_entry.half
                                   |-> $past(state_q, BIT_CYC * 8) == S_LO)
        else $error("high byte not after low");
    a_one_wait: assert property (req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST)
        else $error("bus answer late");

    // bus, fifo, sequencer and pin level
    a_ready_once: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
        else $error("bus answer held too long");
    a_count_bound: assert property (count_q <= CNT_W'(FIFO_DEPTH))
        else $error("fifo count beyond depth");
    a_pop_advance: assert property (pop && !flush |=> rd_ptr_q == PTR_W'($past(rd_ptr_q) + 1'b1))
        else $error("read did not advance head");
    a_start_seen: assert property (state_q == S_START && bit_en && !I_LINE_START
                                   && {start_q[1:0], sliced} == START_CODE |=> state_q == S_LO)
        else $error("start pattern missed");
    a_irq_level: assert property (1'b1 |=> O_IRQ == $past(|(irq_stat_q & irq_mask_q)))
        else $error("event interrupt level wrong");

    c_overflow: cover property (push_req && full);
    c_read_write: cover property (pop && push_req);
    c_half_irq: cover property ($rose(O_CC_IRQ));
    c_flush_data: cover property (flush && count_q != '0);
    c_high_byte: cover property (push_ok && push_entry.half);

endmodule : ccdec_top

// *** sim/ccdec_host.sv ***
`timescale 1ns/1ns
module ccdec_host
    import ccdec_pkg::*;
(
    // bus clock
    input  wire logic              i_clk,
    // slave answer
    input  wire logic [31:0]       i_readdata,
    input  wire logic              i_waitrequest,
    // master request
    output logic      [ADDR_W-1:0] o_address,
    output logic                   o_read,
    output logic                   o_write,
    output logic      [31:0]       o_writedata,
    output logic      [3:0]        o_byteenable
);
    initial begin
        o_address    = '0;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = '0;
        o_byteenable = 4'h0;
    end

    // ************************************************
    // transfers
    // ************************************************
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                        input logic [3:0] be, output logic [31:0] rdata);
        o_address    <= {idx, 2'b00};
        o_read       <= ~wr;
        o_write      <= wr;
        o_writedata  <= {24'h0, wd};
        o_byteenable <= be;
        @(posedge i_clk);
        while (i_waitrequest !== 1'b0) begin
            @(posedge i_clk);
        end
        rdata = i_readdata;
        o_read      <= 1'b0;
        o_write     <= 1'b0;
        // released lines must not keep looking valid
        o_address   <= ~o_address;
        o_writedata <= ~o_writedata;
        // idle edge, so the next call never re-drives in this time step
        @(posedge i_clk);
    endtask : xfer

    // a pop that met a push leaves overflow set, so read once more
    task automatic pop_clear(output logic [31:0] first, output logic extra);
        logic [31:0] st;
        logic [31:0] dummy;
        xfer(1'b0, IDX_FIFO_READ, 8'h00, 4'hF, first);
        xfer(1'b0, IDX_FIFO_STATUS, 8'h00, 4'hF, st);
        extra = st[FS_OVERFLOW];
        if (extra === 1'b1) begin
            xfer(1'b0, IDX_FIFO_READ, 8'h00, 4'hF, dummy);
        end
    endtask : pop_clear
endmodule : ccdec_host

// *** sim/ccdec_top_tb_top.sv ***
`timescale 1ns/1ns
`define CHK(a, e, m) begin comparisons++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, a, e); end end
module ccdec_top_tb_top import ccdec_pkg::*;;
    // ************************************************
    // signals
    // ************************************************
    typedef struct packed {
        logic [1:0] en;
        logic       odd;
        logic       ri;
        logic [7:0] lo;
        logic [7:0] hi;
        logic       cap;
    } ccdec_row_t;
    localparam logic [7:0] LV_LO = 8'h10;
    localparam logic [7:0] LV_HI = 8'hC0;
    localparam int         LIMIT = 60000;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [7:0]        luma = 8'h10;
    logic              line_st = 1'b0;
    logic              field_st = 1'b0;
    logic              field_odd = 1'b0;
    logic [ADDR_W-1:0] avs_addr;
    logic              avs_rd;
    logic              avs_wr;
    logic [31:0]       avs_wd;
    logic [3:0]        avs_be;
    logic [31:0]       avs_rdata;
    logic              avs_wait;
    logic              cap_irq;
    logic              irq;
    int                error_cnt = 0;
    int                comparisons = 0;
    int                cyc = 0;
    logic [7:0]        exp_q[$];
    ccdec_row_t        rows[6] = '{{2'b01, 1'b1, 1'b1, 8'hC1, 8'h42, 1'b1},
                                   {2'b10, 1'b0, 1'b1, 8'h04, 8'h85, 1'b1},
                                   {2'b01, 1'b0, 1'b1, 8'hC1, 8'h42, 1'b0},
                                   {2'b10, 1'b1, 1'b1, 8'hC1, 8'h42, 1'b0},
                                   {2'b11, 1'b0, 1'b1, 8'h7F, 8'h00, 1'b1},
                                   {2'b01, 1'b1, 1'b0, 8'hC1, 8'h42, 1'b0}};

    always #50 clk = ~clk;

    ccdec_top u_ccdec_top (
        .I_CLK(clk), .I_SYS_RST(rst), .I_LUMA(luma), .I_LINE_START(line_st),
        .I_FIELD_START(field_st), .I_FIELD_ODD(field_odd), .I_AVS_ADDRESS(avs_addr),
        .I_AVS_READ(avs_rd), .I_AVS_WRITE(avs_wr), .I_AVS_WRITEDATA(avs_wd),
        .I_AVS_BYTEENABLE(avs_be), .O_AVS_READDATA(avs_rdata),
        .O_AVS_WAITREQUEST(avs_wait), .O_CC_IRQ(cap_irq), .O_IRQ(irq));

    ccdec_host u_ccdec_host (
        .i_clk(clk), .i_readdata(avs_rdata), .i_waitrequest(avs_wait),
        .o_address(avs_addr), .o_read(avs_rd), .o_write(avs_wr),
        .o_writedata(avs_wd), .o_byteenable(avs_be));

    // ************************************************
    // tasks
    // ************************************************
    function automatic logic [7:0] oddp(input logic [6:0] c);
        return {~^c, c};
    endfunction : oddp

    task automatic hold(input logic [7:0] v, input int n);
        luma <= v;
        repeat (n) @(posedge clk);
    endtask : hold

    // data sent on four lines around the target, so only the counter picks the line
    task automatic send_field(input logic odd, input logic ri, input logic [7:0] lo,
                              input logic [7:0] hi);
        logic [18:0] bits;
        bits = {hi, lo, 3'b100};
        field_odd <= odd;
        field_st <= 1'b1;
        @(posedge clk);
        field_st <= 1'b0;
        hold(LV_LO, 3);
        for (int n = 1; n <= 22; n++) begin
            line_st <= 1'b1;
            @(posedge clk);
            line_st <= 1'b0;
            if (n < 19) begin
                hold(LV_LO, 4);
            end else begin
                hold(LV_LO, 10);
                for (int k = 0; k < 4; k++) begin
                    hold(LV_LO, 9);
                    hold(ri ? LV_HI : LV_LO, (k < 3) ? 10 : 1);
                end
                for (int b = 0; b < 19; b++) begin
                    hold(bits[b] ? LV_HI : LV_LO, 19);
                end
                hold(LV_LO, 20);
            end
        end
    endtask : send_field

    task automatic rchk(input logic [7:0] idx, input logic [7:0] e, input string m);
        logic [31:0] v;
        u_ccdec_host.xfer(1'b0, idx, 8'h00, 4'hF, v);
        `CHK(v, {24'h0, e}, m)
    endtask : rchk

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        logic [31:0] v;
        u_ccdec_host.xfer(1'b1, idx, d, be, v);
    endtask : wr

    task automatic pin(ref logic a, input logic e, input string m);
        repeat (3) @(posedge clk);
        `CHK(a, e, m)
    endtask : pin

    task automatic end_test(input string name);
        $display("test %s done, checks %0d, errors %0d", name, comparisons, error_cnt);
    endtask : end_test

    task automatic finish_test();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t timeout", $time);
            finish_test();
        end
    end

    // ************************************************
    // sequence
    // ************************************************
    initial begin
        logic [31:0] v;
        logic        extra;
        logic [7:0]  e8;
        repeat (12) @(posedge clk);
        `CHK(avs_wait, 1'b1, "wait in reset")
        `CHK(cap_irq, 1'b0, "pin in reset")
        rst <= 1'b0;
        @(posedge clk);
        rchk(IDX_FIFO_STATUS, 8'h00, "status rst");
        rchk(IDX_IRQ_MASK, 8'h00, "mask rst");
        end_test("reset");
        for (int r = 0; r < 6; r++) begin
            ccdec_row_t w;
            w = rows[r];
            wr(IDX_FIFO_STATUS, {w.en, 6'h00}, 4'h1);
            send_field(w.odd, w.ri, w.lo, w.hi);
            if (w.cap) begin
                rchk(IDX_FIFO_STATUS, {w.en, 1'b0, ~^w.lo, ~w.odd, 3'b001}, "lo");
                rchk(IDX_FIFO_READ, w.lo, "lo byte");
                rchk(IDX_FIFO_STATUS, {w.en, 1'b0, ~^w.hi, ~w.odd, 3'b101}, "hi");
                rchk(IDX_FIFO_READ, w.hi, "hi byte");
            end
            rchk(IDX_FIFO_STATUS, {w.en, 6'h00}, "empty");
            rchk(IDX_FIFO_READ, 8'h00, "empty read");
        end
        end_test("rows");
        wr(IDX_FIFO_STATUS, 8'h60, 4'h1);
        wr(IDX_IRQ_STATUS, 8'h07, 4'h1);
        wr(IDX_IRQ_MASK, 8'h07, 4'h1);
        for (int k = 0; k < 9; k++) begin
            send_field(1'b1, 1'b1, oddp(7'(2 * k)), oddp(7'(2 * k + 1)));
            if (k < 8) begin
                exp_q.push_back(oddp(7'(2 * k)));
                exp_q.push_back(oddp(7'(2 * k + 1)));
            end
            pin(cap_irq, (k >= 3), "half pin");
        end
        rchk(IDX_FIFO_STATUS, 8'h63, "full ovf");
        wr(IDX_FIFO_STATUS, 8'h40, 4'h1);
        pin(cap_irq, 1'b0, "pin disabled");
        rchk(IDX_DEVICE_STATUS, 8'h01, "half polled");
        pin(irq, 1'b1, "event irq");
        wr(IDX_IRQ_MASK, 8'h00, 4'h1);
        pin(irq, 1'b0, "masked");
        wr(IDX_IRQ_MASK, 8'h07, 4'h1);
        wr(IDX_FIFO_STATUS, 8'h60, 4'h1);
        u_ccdec_host.pop_clear(v, extra);
        e8 = exp_q.pop_front();
        `CHK(v, {24'h0, e8}, "first pop")
        `CHK(extra, 1'b0, "ovf cleared")
        send_field(1'b1, 1'b1, 8'h86, 8'h07);
        exp_q.push_back(8'h86);
        rchk(IDX_FIFO_STATUS, 8'h67, "lo takes last slot");
        while (exp_q.size() > 0) begin
            rchk(IDX_FIFO_READ, exp_q.pop_front(), "drain");
        end
        rchk(IDX_FIFO_STATUS, 8'h60, "drained");
        pin(cap_irq, 1'b0, "below half");
        rchk(IDX_IRQ_STATUS, 8'h03, "events");
        wr(IDX_IRQ_STATUS, 8'h07, 4'h1);
        pin(irq, 1'b0, "cleared");
        end_test("fill");
        send_field(1'b1, 1'b1, 8'hC1, 8'h42);
        wr(IDX_FIFO_STATUS, 8'h00, 4'hE);
        rchk(IDX_FIFO_STATUS, 8'h61, "lane off");
        wr(8'h05, 8'hFF, 4'h1);
        rchk(8'h05, 8'h00, "unmapped");
        wr(IDX_FIFO_STATUS, 8'h00, 4'h1);
        wr(IDX_FIFO_STATUS, 8'h40, 4'h1);
        rchk(IDX_FIFO_STATUS, 8'h40, "flushed");
        rchk(IDX_FIFO_READ, 8'h00, "flushed read");
        end_test("refuse");
        finish_test();
    end
endmodule : ccdec_top_tb_top
